/* File: include/ttr_pkg.sv */
package ttr_pkg;

  // register map, one aligned word each
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_CHARS  = 32'h0000_0008;

  // control word fields
  localparam int          CTRL_DIV_LSB  = 0;
  localparam int          CTRL_TEST_BIT = 8;
  localparam logic [7:0]  CTRL_DIV_RST  = 8'h10;
  localparam logic        CTRL_TEST_RST = 1'b0;

  // status word fields
  localparam int ST_GAP_BIT    = 0;
  localparam int ST_GATE_BIT   = 1;
  localparam int ST_SKEW_BIT   = 2;
  localparam int ST_DELAY_BIT  = 3;
  localparam int ST_GAPCNT_LSB = 8;

  // skew counter presets and close point
  localparam logic [4:0] SKEW_PRESET_TEST  = 5'h0B;
  localparam logic [4:0] SKEW_PRESET_WRITE = 5'h04;
  localparam logic [4:0] SKEW_PRESET_READ  = 5'h00;
  localparam logic [4:0] SKEW_CLOSE        = 5'h10;

  // gap counter marks
  localparam logic [7:0] GAP_FLAG_COUNT = 8'h20;
  localparam logic [7:0] GAP_ARM_COUNT  = 8'h20;

  // start-up delay terminal bit (count of 128)
  localparam int DELAY_DONE_BIT = 7;

  // last fast clock count of a character clock half period (16 fast clocks per half)
  localparam logic [4:0] CHAR_HALF_LAST = 5'h0F;

  // timing
  localparam int         CLK_PERIOD_NS    = 20;
  localparam int         SKEW_STRETCH_NS  = 10000;
  localparam logic [9:0] SKEW_STRETCH_CYC =
    10'((SKEW_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [3:0] {
    SK_IDLE   = 4'b0001,
    SK_OPEN   = 4'b0010,
    SK_XFER   = 4'b0100,
    SK_STROBE = 4'b1000
  } ttr_skew_state_t;

  typedef struct packed {
    logic busy;
    logic load_point;
    logic selected;
    logic run;
    logic write_ready;
    logic peak;
  } ttr_pins_t;

  typedef struct packed {
    logic [7:0] div_half;
    logic       test_mode;
  } ttr_ctrl_t;

endpackage

/* File: rtl/ttr_read_timing.sv */
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - produce a fast clock at 32x character rate and a character-rate clock.
// - both clocks divide the master clock by a software-selected ratio.
// - ORed channel peaks form the one character input, admitted while window open.
// - leading peak of a character starts the skew counter on the fast clock.
// - test mode presets the counter to 11; at 16 the window closes.
// - write ready without test mode presets to four, twelve counts tolerance.
// - read only gives sixteen counts, half a character.
// - window close raises the character transfer pulse.
// - next fast edge raises the read strobe for one fast period.
// - a peak after the window closed flags skew error, stretched indicator.
// - gap counter of two 4-bit stages on fast clock, cleared per character.
// - at count 32 the gap flag sets, only when selected and on line.
// - while the gap flag is set and the counter is not armed, characters do not clear the counter.
// - 256 plus 32 more counts arm the counter to clear on next character.
// - read gate needs not busy, not load point, selected, run, delay done.
// - normal run starts an 8-bit delay on character clock, done at 128.
// - at the terminal count the delay counter stops and holds.
// - rising normal run resets the delay counter to zero.
// - read gate enables channel output gates, off during ramp-up.
module ttr_read_timing (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        PEAK_PULSE_OR,
  input  wire logic        WRITE_READY_FLAG,
  input  wire logic        TRANSPORT_BUSY_LINE,
  input  wire logic        LOAD_POINT_FLAG,
  input  wire logic        UNIT_SELECTED_ONLINE,
  input  wire logic        NORMAL_RUN_MOTION,
  output logic             FAST_BIT_CLOCK,
  output logic             CHAR_RATE_CLOCK,
  output logic             CHAR_TRANSFER,
  output logic             READ_CHAR_STROBE,
  output logic             SKEW_INDICATOR,
  output logic             GAP_DETECT,
  output logic             READ_GATE_ENABLE
);
  import ttr_pkg::*;

  ttr_pins_t       pin_meta;
  ttr_pins_t       pins;
  logic            peak_last;
  logic            run_last;
  logic            peak_evt;
  logic            run_rise;
  ttr_ctrl_t       ctrl;
  logic [7:0]      div_cnt;
  logic [7:0]      div_last;
  logic            fast_tick;
  logic            char_tick;
  logic [4:0]      char_phase;
  ttr_skew_state_t skew_state;
  logic [4:0]      skew_cnt;
  logic [4:0]      skew_preset;
  logic            data_char;
  logic            skew_err;
  logic            skew_sticky;
  logic [9:0]      stretch_cnt;
  logic [7:0]      gap_cnt;
  logic [7:0]      next_gap_cnt;
  logic            gap_passed;
  logic            gap_armed;
  logic            gap_flag;
  logic [7:0]      delay_cnt;
  logic            delay_done;
  logic [15:0]     char_count;
  logic [31:0]     addr_q;
  logic            wr_q;
  logic            rd_pend;
  logic            bus_take;
  logic            skew_clr;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; edge detectors look only at the second stage

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pin_meta  <= '0;
      pins      <= '0;
      peak_last <= 1'b0;
      run_last  <= 1'b0;
    end else begin
      pin_meta  <= '{busy: TRANSPORT_BUSY_LINE, load_point: LOAD_POINT_FLAG,
                     selected: UNIT_SELECTED_ONLINE, run: NORMAL_RUN_MOTION,
                     write_ready: WRITE_READY_FLAG, peak: PEAK_PULSE_OR};
      pins      <= pin_meta;
      peak_last <= pins.peak;
      run_last  <= pins.run;
    end
  end

  assign peak_evt = pins.peak & ~peak_last;
  assign run_rise = pins.run & ~run_last;

  //////////////////////////////////////////////////////////////////////////////
  // clock dividers; the clocks are outputs, inside we run on ticks

  assign div_last  = (ctrl.div_half == 8'h00) ? 8'h00 : ctrl.div_half - 8'h01;
  assign fast_tick = (div_cnt >= div_last) & ~FAST_BIT_CLOCK;
  assign char_tick = fast_tick & (char_phase == CHAR_HALF_LAST);

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      div_cnt        <= 8'h00;
      FAST_BIT_CLOCK <= 1'b0;
    end else if (div_cnt >= div_last) begin
      div_cnt        <= 8'h00;
      FAST_BIT_CLOCK <= ~FAST_BIT_CLOCK;
    end else begin
      div_cnt        <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      char_phase      <= 5'h00;
      CHAR_RATE_CLOCK <= 1'b0;
    end else if (fast_tick) begin
      char_phase      <= char_phase + 5'h01;
      CHAR_RATE_CLOCK <= char_phase[4] ^ (char_phase[3:0] == 4'hF);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // skew window, transfer pulse and read strobe

  always_comb begin
    if (ctrl.test_mode) begin
      skew_preset = SKEW_PRESET_TEST;
    end else if (pins.write_ready) begin
      skew_preset = SKEW_PRESET_WRITE;
    end else begin
      skew_preset = SKEW_PRESET_READ;
    end
  end

  assign data_char = peak_evt & (skew_state == SK_IDLE);
  assign skew_err  = peak_evt & (skew_state != SK_IDLE) & (skew_state != SK_OPEN);

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      skew_state       <= SK_IDLE;
      skew_cnt         <= 5'h00;
      CHAR_TRANSFER    <= 1'b0;
      READ_CHAR_STROBE <= 1'b0;
    end else begin
      unique case (skew_state)
        SK_IDLE: begin
          if (data_char) begin
            skew_cnt   <= skew_preset;
            skew_state <= SK_OPEN;
          end
        end
        SK_OPEN: begin
          if (fast_tick) begin
            skew_cnt <= skew_cnt + 5'h01;
            if (skew_cnt + 5'h01 == SKEW_CLOSE) begin
              skew_state    <= SK_XFER;
              CHAR_TRANSFER <= 1'b1;
            end
          end
        end
        SK_XFER: begin
          if (fast_tick) begin
            skew_state       <= SK_STROBE;
            CHAR_TRANSFER    <= 1'b0;
            READ_CHAR_STROBE <= 1'b1;
          end
        end
        SK_STROBE: begin
          if (fast_tick) begin
            skew_state       <= SK_IDLE;
            READ_CHAR_STROBE <= 1'b0;
          end
        end
      endcase
    end
  end

  // stretched so that a lamp can show a single late peak
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      stretch_cnt    <= 10'h000;
      SKEW_INDICATOR <= 1'b0;
    end else if (skew_err) begin
      stretch_cnt    <= SKEW_STRETCH_CYC;
      SKEW_INDICATOR <= 1'b1;
    end else begin
      stretch_cnt    <= (stretch_cnt == 10'h000) ? 10'h000 : stretch_cnt - 10'h001;
      SKEW_INDICATOR <= stretch_cnt > 10'h001;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      skew_sticky <= 1'b0;
    end else begin
      skew_sticky <= skew_err | (skew_sticky & ~skew_clr);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      char_count <= 16'h0000;
    end else if (fast_tick && skew_state == SK_XFER) begin
      char_count <= char_count + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrecord gap detection

  assign next_gap_cnt = gap_cnt + 8'h01;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gap_cnt    <= 8'h00;
      gap_passed <= 1'b0;
      gap_armed  <= 1'b0;
      gap_flag   <= 1'b0;
    end else if (!pins.selected) begin
      gap_flag   <= 1'b0;
      gap_armed  <= 1'b0;
      gap_passed <= 1'b0;
      if (data_char) begin
        gap_cnt <= 8'h00;
      end else if (fast_tick) begin
        gap_cnt <= next_gap_cnt;
      end
    end else if (data_char && (!gap_flag || gap_armed)) begin
      gap_cnt    <= 8'h00;
      gap_flag   <= 1'b0;
      gap_armed  <= 1'b0;
      gap_passed <= 1'b0;
    end else if (fast_tick && !gap_armed) begin
      gap_cnt <= next_gap_cnt;
      if (gap_cnt == 8'hFF && gap_flag) begin
        gap_passed <= 1'b1;
      end
      if (next_gap_cnt == GAP_FLAG_COUNT && !gap_flag) begin
        gap_flag <= 1'b1;
      end
      if (next_gap_cnt == GAP_ARM_COUNT && gap_passed) begin
        gap_armed <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      GAP_DETECT <= 1'b0;
    end else begin
      GAP_DETECT <= gap_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // start-up delay and read gate

  assign delay_done = delay_cnt[DELAY_DONE_BIT];

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      delay_cnt <= 8'h00;
    end else if (run_rise) begin
      delay_cnt <= 8'h00;
    end else if (char_tick && pins.run && !delay_done) begin
      delay_cnt <= delay_cnt + 8'h01;
    end
  end

  // gate stays off through ramp-up so noise never reaches the outputs
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      READ_GATE_ENABLE <= 1'b0;
    end else begin
      READ_GATE_ENABLE <= ~pins.busy & ~pins.load_point & pins.selected
                          & pins.run & delay_done & ~run_rise;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait state

  assign bus_take = HSEL & HREADY & HTRANS[1];
  assign skew_clr = wr_q & (addr_q == ADDR_STATUS) & HWDATA[ST_SKEW_BIT];

  function automatic logic [31:0] read_word(input logic [31:0] addr);
    logic [31:0] word;
    word = 32'h0000_0000;
    if (addr == ADDR_CTRL) begin
      word[CTRL_DIV_LSB +: 8] = ctrl.div_half;
      word[CTRL_TEST_BIT]     = ctrl.test_mode;
    end else if (addr == ADDR_STATUS) begin
      word[ST_GAP_BIT]          = gap_flag;
      word[ST_GATE_BIT]         = READ_GATE_ENABLE;
      word[ST_SKEW_BIT]         = skew_sticky;
      word[ST_DELAY_BIT]        = delay_done;
      word[ST_GAPCNT_LSB +: 8]  = gap_cnt;
    end else if (addr == ADDR_CHARS) begin
      word[15:0] = char_count;
    end
    return word;
  endfunction

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      addr_q    <= 32'h0000_0000;
      wr_q      <= 1'b0;
      rd_pend   <= 1'b0;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HRESP <= 1'b0;
      if (rd_pend) begin
        HRDATA    <= read_word(addr_q);
        HREADYOUT <= 1'b1;
        rd_pend   <= 1'b0;
        wr_q      <= 1'b0;
      end else begin
        addr_q    <= {HADDR[31:2], 2'b00};
        wr_q      <= bus_take & HWRITE;
        rd_pend   <= bus_take & ~HWRITE;
        HREADYOUT <= ~(bus_take & ~HWRITE);
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ctrl <= '{div_half: CTRL_DIV_RST, test_mode: CTRL_TEST_RST};
    end else if (wr_q && addr_q == ADDR_CTRL) begin
      ctrl <= '{div_half: HWDATA[CTRL_DIV_LSB +: 8], test_mode: HWDATA[CTRL_TEST_BIT]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence s_xfer_done;
    $fell(CHAR_TRANSFER) ##0 READ_CHAR_STROBE;
  endsequence
  // slowest fast period is 510 cycles, so the strobe must drop well inside 600
  sequence s_strobe_end;
    READ_CHAR_STROBE ##[1:600] !READ_CHAR_STROBE;
  endsequence

  property p_strobe_after_xfer;
    $fell(CHAR_TRANSFER) |-> s_xfer_done;
  endproperty
  a_strobe_after_xfer: assert property (p_strobe_after_xfer)
    else $error("strobe did not follow transfer");

  property p_strobe_source;
    $rose(READ_CHAR_STROBE) |-> $past(CHAR_TRANSFER) && !CHAR_TRANSFER;
  endproperty
  a_strobe_source: assert property (p_strobe_source)
    else $error("strobe rose without transfer");

  property p_strobe_end;
    $rose(READ_CHAR_STROBE) |-> s_strobe_end;
  endproperty
  a_strobe_end: assert property (p_strobe_end)
    else $error("strobe did not end");

  property p_preset_test;
    data_char && ctrl.test_mode |=> skew_cnt == 5'h0B;
  endproperty
  a_preset_test: assert property (p_preset_test)
    else $error("test preset wrong");

  property p_preset_write;
    data_char && !ctrl.test_mode && pins.write_ready |=> skew_cnt == 5'h04;
  endproperty
  a_preset_write: assert property (p_preset_write)
    else $error("write preset wrong");

  property p_preset_read;
    data_char && !ctrl.test_mode && !pins.write_ready |=> skew_cnt == 5'h00;
  endproperty
  a_preset_read: assert property (p_preset_read)
    else $error("read preset wrong");

  property p_close_xfer;
    skew_state == SK_OPEN && fast_tick && skew_cnt == 5'h0F |=> CHAR_TRANSFER;
  endproperty
  a_close_xfer: assert property (p_close_xfer)
    else $error("window close without transfer");

  property p_skew_flag;
    skew_err |=> skew_sticky ##1 SKEW_INDICATOR;
  endproperty
  a_skew_flag: assert property (p_skew_flag)
    else $error("late peak not flagged");

  property p_gap_set;
    pins.selected && fast_tick && !gap_armed && !data_char && !gap_flag
      && gap_cnt == 8'h1F |=> gap_flag ##1 GAP_DETECT;
  endproperty
  a_gap_set: assert property (p_gap_set)
    else $error("gap flag missed");

  property p_gap_hold;
    pins.selected && gap_flag && !gap_armed && data_char && gap_cnt != 8'hFF
      |=> gap_cnt >= $past(gap_cnt);
  endproperty
  a_gap_hold: assert property (p_gap_hold)
    else $error("gap counter cleared during gap");

  property p_gate_cond;
    READ_GATE_ENABLE |-> $past(delay_done) && $past(pins.selected) && !$past(pins.busy);
  endproperty
  a_gate_cond: assert property (p_gate_cond)
    else $error("read gate without conditions");

  property p_delay_hold;
    delay_done && !run_rise |=> $stable(delay_cnt);
  endproperty
  a_delay_hold: assert property (p_delay_hold)
    else $error("delay counter moved after done");

  property p_delay_reset;
    run_rise |=> delay_cnt == 8'h00 ##1 !READ_GATE_ENABLE;
  endproperty
  a_delay_reset: assert property (p_delay_reset)
    else $error("delay not reset on run");

endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import ttr_pkg::*;
  localparam logic [31:0] ADDR_NONE = 32'h0000_000C;
  localparam int          DIV       = 2;
  localparam int          LIMIT     = 40000;
  logic        clock  = 1'b0;
  logic        reset  = 1'b1;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        fire   = 1'b0;
  logic        wr_rdy = 1'b0;
  logic        busy   = 1'b0;
  logic        lp     = 1'b0;
  logic        sel    = 1'b0;
  logic        run    = 1'b0;
  logic        fast_q = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        peak;
  logic        fast_clk;
  logic        char_clk;
  logic        xfer;
  logic        strobe;
  logic        skew_ind;
  logic        gap;
  logic        gate;
  logic [31:0] rd;
  int          errors   = 0;
  int          compares = 0;
  int          cycles   = 0;
  int          ticks    = 0;
  int          strobes;
  int          n;
  int          a;
  int          b;
  int          t0;
  int          d [3];
  ////////////////////////////////////////////////////////////////////////////////
  always #10 clock = ~clock;
  ttr_read_timing dut_u (
    .CLOCK(clock), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PEAK_PULSE_OR(peak), .WRITE_READY_FLAG(wr_rdy),
    .TRANSPORT_BUSY_LINE(busy), .LOAD_POINT_FLAG(lp), .UNIT_SELECTED_ONLINE(sel),
    .NORMAL_RUN_MOTION(run), .FAST_BIT_CLOCK(fast_clk), .CHAR_RATE_CLOCK(char_clk),
    .CHAR_TRANSFER(xfer), .READ_CHAR_STROBE(strobe), .SKEW_INDICATOR(skew_ind),
    .GAP_DETECT(gap), .READ_GATE_ENABLE(gate));
  ttr_tape_partner partner_u (
    .clk(clock), .rst(reset), .fire(fire), .strobe(strobe), .peak(peak), .strobes(strobes));
  // fast clock rises tallied on the system clock, window lengths in ticks
  always @(posedge clock) begin
    fast_q <= fast_clk;
    if (fast_clk && !fast_q) ticks <= ticks + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic pick(input int w);
    case (w)
      0: pick = xfer;
      1: pick = strobe;
      2: pick = skew_ind;
      3: pick = gap;
      4: pick = gate;
      5: pick = fast_clk;
      default: pick = char_clk;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    compares++;
    if (got != exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge; waits only on hready
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] ad, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, ad, 32'h0000_0000);
    chk(rd & m, e);
    chk(hresp, 1'b0);
  endtask
  task automatic wait_for(input int w, input logic lvl, input int lim, output int k);
    k = 0;
    while (pick(w) !== lvl && k < lim) begin
      @(posedge clock);
      k++;
    end
  endtask
  task automatic period(input int w, output int hi, output int lo);
    wait_for(w, 1'b0, 5000, hi);
    wait_for(w, 1'b1, 5000, hi);
    wait_for(w, 1'b0, 5000, hi);
    wait_for(w, 1'b1, 5000, lo);
  endtask
  task automatic fire_char();
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask
  task automatic final_report();
    $display("counts: compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    rd_chk(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0010);
    rd_chk(ADDR_STATUS, 32'h0000_000F, 32'h0000_0000);
    ahb(1'b1, ADDR_NONE, 32'hFFFF_FFFF);
    rd_chk(ADDR_NONE, 32'hFFFF_FFFF, 32'h0000_0000);
    end_test("registers");
    period(5, a, b);
    chk_n(a + b, 32);
    ahb(1'b1, ADDR_CTRL, 32'(DIV));
    period(5, a, b);
    chk_n(a, DIV);
    chk_n(b, DIV);
    period(6, a, b);
    chk_n(a, 32 * DIV);
    chk_n(b, 32 * DIV);
    end_test("clocks");
    // test, write ready, read only; offsets cancel in the differences
    for (int m = 0; m < 3; m++) begin
      ahb(1'b1, ADDR_CTRL, 32'(DIV) | ((m == 0) ? 32'h0000_0100 : 32'h0000_0000));
      wr_rdy <= (m != 2);
      repeat (6) @(posedge clock);
      t0 = ticks;
      fire_char();
      wait_for(0, 1'b1, 400, n);
      d[m] = ticks - t0;
      wait_for(1, 1'b1, 40, a);
      chk_n(a, 2 * DIV);
      chk(xfer, 1'b0);
      wait_for(1, 1'b0, 40, b);
      chk_n(b, 2 * DIV);
      repeat (20) @(posedge clock);
    end
    chk_n(d[2] - d[0], 11);
    chk_n(d[2] - d[1], 4);
    chk_n(int'(d[2] >= 16 && d[2] <= 19), 1);
    chk(skew_ind, 1'b0);
    rd_chk(ADDR_CHARS, 32'h0000_FFFF, 32'h0000_0003);
    chk_n(strobes, 3);
    end_test("skew windows");
    fire_char();
    wait_for(0, 1'b1, 400, n);
    fire_char(); // peak after the window closed
    wait_for(2, 1'b1, 40, n);
    chk(skew_ind, 1'b1);
    wait_for(2, 1'b0, 700, n);
    chk_n(int'(n >= 450), 1);
    rd_chk(ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
    ahb(1'b1, ADDR_STATUS, 32'h0000_0004);
    rd_chk(ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
    end_test("skew error");
    fire_char();
    repeat (200) @(posedge clock);
    chk(gap, 1'b0);
    sel <= 1'b1;
    repeat (4) @(posedge clock);
    fire_char();
    repeat (100) @(posedge clock);
    chk(gap, 1'b0);
    wait_for(3, 1'b1, 100, n);
    chk(gap, 1'b1);
    fire_char(); // check character inside the gap
    repeat (100) @(posedge clock);
    chk(gap, 1'b1);
    repeat (1100) @(posedge clock);
    chk(gap, 1'b1);
    fire_char();
    wait_for(3, 1'b0, 60, n);
    chk(gap, 1'b0);
    end_test("gap");
    chk(gate, 1'b0);
    run <= 1'b1;
    repeat (100 * 64 * DIV) @(posedge clock);
    chk(gate, 1'b0);
    wait_for(4, 1'b1, 40 * 64 * DIV, n);
    chk(gate, 1'b1);
    rd_chk(ADDR_STATUS, 32'h0000_000A, 32'h0000_000A);
    repeat (20 * 64 * DIV) @(posedge clock);
    chk(gate, 1'b1);
    for (int i = 0; i < 3; i++) begin
      busy <= (i == 0);
      lp <= (i == 1);
      sel <= (i != 2);
      repeat (6) @(posedge clock);
      chk(gate, 1'b0);
    end
    busy <= 1'b0;
    lp <= 1'b0;
    sel <= 1'b1;
    repeat (6) @(posedge clock);
    chk(gate, 1'b1);
    run <= 1'b0;
    repeat (6) @(posedge clock);
    chk(gate, 1'b0);
    run <= 1'b1;
    repeat (6) @(posedge clock);
    chk(gate, 1'b0);
    rd_chk(ADDR_STATUS, 32'h0000_0008, 32'h0000_0000);
    end_test("read gate");
    final_report();
  end
endmodule

/* File: testbench/ttr_tape_partner.sv */
`timescale 1ns/1ns
// far side: read channels ORed onto one peak line, plus a strobe tally
module ttr_tape_partner (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic fire,
  input  wire logic strobe,
  output logic      peak,
  output int        strobes
);
  logic [3:0] age;
  logic       strobe_q;
  ////////////////////////////////////////////////////////////////////////////////
  // lagging channel seven cycles late, inside every tolerance
  always_ff @(posedge clk) begin
    if (rst) begin
      age      <= 4'h0;
      peak     <= 1'b0;
      strobes  <= 0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe;
      if (strobe && !strobe_q) strobes <= strobes + 1;
      if (fire) age <= 4'h1;
      else if (age != 4'h0 && age != 4'hC) age <= age + 4'h1;
      else age <= 4'h0;
      peak <= (age == 4'h1) || (age == 4'h2) || (age == 4'h8) || (age == 4'h9);
    end
  end
endmodule
